// ### src/alarm_pkg.sv
package alarm_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned OVL2_TIME_MS = 1000;
	localparam int unsigned OVL2_CYCLES = CLK_HZ / 1000 * OVL2_TIME_MS;
	localparam int unsigned ABS_TIMEOUT_MS = 5000;
	localparam int unsigned ABS_CYCLES = CLK_HZ / 1000 * ABS_TIMEOUT_MS;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_SOFT_FWD = 8'h0C;
	localparam logic [7:0] OFS_SOFT_REV = 8'h10;
	localparam logic [7:0] OFS_OVL_LEVEL = 8'h14;
	localparam logic [7:0] OFS_GEAR_NUM = 8'h18;
	localparam logic [7:0] OFS_GEAR_DEN = 8'h1C;
	localparam logic [7:0] OFS_LIVE = 8'h20;
	localparam logic [7:0] OFS_CMD = 8'h24;

	// ----------------------------------------------------------------
	// Alarm bit positions (status, mask and live share the layout)
	// ----------------------------------------------------------------
	localparam int ALM_OVL2 = 0;
	localparam int ALM_MISMATCH = 1;
	localparam int ALM_ESTOP = 2;
	localparam int ALM_HWLIM = 3;
	localparam int ALM_SWFWD = 4;
	localparam int ALM_SWREV = 5;
	localparam int ALM_OVLWARN = 6;
	localparam int ALM_ABSTO = 7;
	localparam int ALM_POSCMD = 8;
	localparam int ALM_W = 9;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_ABS_SYSTEM = 0;
	localparam int CTRL_OVLWARN_EN = 1;
	localparam int CTRL_PRMODE = 2;
	localparam int CTRL_W = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h2;

	// Command register fields (write-only pulses).
	localparam int CMD_ABS_POS = 0;
	localparam int CMD_HOME_DONE = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] SOFT_FWD_RESET = 32'h7FFF_FFFF;
	localparam logic [31:0] SOFT_REV_RESET = 32'h8000_0000;
	localparam logic [15:0] OVL_LEVEL_RESET = 16'h2710;
	localparam logic [15:0] GEAR_RESET = 16'h0001;

	// Capacity compatibility: motor capacity code may be this far below.
	localparam logic [7:0] CAP_SPAN = 8'h01;

	// AHB transfer type.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ### src/alarm_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Run-length timer
// ----------------------------------------------------------------
// Counts cycles while run is high and flags once the count exceeds the
// limit; dropping run restarts it, so only an unbroken run is measured.
module alarm_timer #(
	parameter int unsigned LIMIT = 10
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Control.
	alarm_timer_if.timer tmr
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic over_r;

	assign cnt_nxt = (cnt_r == LIMIT) ? cnt_r : cnt_r + 32'h0000_0001;

	// Saturating count holds the expired state while run stays high.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 32'h0000_0000;
			over_r <= 1'b0;
		end else if (!tmr.run) begin
			cnt_r <= 32'h0000_0000;
			over_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			over_r <= (cnt_r == LIMIT);
		end
	end

	assign tmr.expired = over_r;

endmodule

`default_nettype wire

// ### src/alarm_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

// Start/expire pair between the monitor and a long-interval timer.
interface alarm_timer_if;
	logic run;
	logic expired;
	modport owner (output run, input expired);
	modport timer (input run, output expired);
endinterface

`default_nettype wire

// ### src/servo_alarm_monitor.sv
// Contract
// R1 - Max current held over 1 s continuously raises overload-2 alarm.
// R2 - Motor capacity incompatible with drive capacity raises mismatch alarm.
// R3 - Emergency stop input raises warning, held until input released.
// R4 - Forward or reverse limit input raises limit-switch alarm.
// R5 - Feedback count above soft forward limit raises software forward alarm.
// R6 - Feedback count below soft reverse limit raises software reverse alarm.
// R7 - Load past permitted time at warn level raises pre-warning; can disable.
// R8 - No host request within 5 s of data ready raises timeout warning.
// R9 - Incremental: absolute command after feedback overflow is a command error.
// R10 - Absolute: feedback register overflow is a command error.
// R11 - Absolute: gear ratio changed without homing since is a command error.
// R12 - Absolute: absolute command while home done is low is a command error.
// R13 - Successful homing clears command error and asserts home done.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module servo_alarm_monitor #(
	parameter int unsigned OVL2_LIMIT = alarm_pkg::OVL2_CYCLES,
	parameter int unsigned ABS_LIMIT = alarm_pkg::ABS_CYCLES
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// AHB-Lite slave.
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Digital inputs from the host and machine.
	input wire logic i_emergency_stop_input,
	input wire logic i_forward_limit_input,
	input wire logic i_reverse_limit_input,
	input wire logic i_abs_data_request,
	// Drive-internal status from the same clock domain.
	input wire logic i_max_current,
	input wire logic i_load_over_level,
	input wire logic [31:0] i_feedback_count,
	input wire logic i_feedback_overflow,
	input wire logic [7:0] i_drive_capacity,
	input wire logic [7:0] i_motor_capacity,
	input wire logic i_abs_data_ready,
	// Outputs.
	output logic o_home_done,
	output logic [alarm_pkg::ALM_W-1:0] o_alarm_live,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;

	// Asynchronous assert, two-flop release avoids recovery hazards.
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Three stages per pin; a level counts only once stages 2 and 3 agree.
	logic [3:0] pin_raw;
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s3_r;
	logic [3:0] pin_r;

	assign pin_raw = {i_abs_data_request, i_reverse_limit_input,
		i_forward_limit_input, i_emergency_stop_input};

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			pin_r <= 4'h0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
		end
	end

	wire estop = pin_r[0];
	wire fwd_lim = pin_r[1];
	wire rev_lim = pin_r[2];
	wire abs_req = pin_r[3];

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic [alarm_pkg::ALM_W-1:0] status_r;
	logic [alarm_pkg::ALM_W-1:0] mask_r;
	logic [alarm_pkg::CTRL_W-1:0] ctrl_r;
	logic [31:0] soft_fwd_r;
	logic [31:0] soft_rev_r;
	logic [15:0] ovl_level_r;
	logic [15:0] gear_num_r;
	logic [15:0] gear_den_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [7:0] rd_addr;
	logic home_done_r;
	logic ovf_seen_r;
	logic gear_dirty_r;

	// Address phase captured; the write lands in the following data phase.
	wire addr_take = i_hsel && i_hready && i_htrans == alarm_pkg::HTRANS_NONSEQ;
	assign rd_addr = i_haddr[7:0];

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_pend_r && (wr_addr_r == ofs);
	endfunction

	wire wr_status = wr_hit(alarm_pkg::OFS_STATUS);
	wire wr_cmd = wr_hit(alarm_pkg::OFS_CMD);
	wire cmd_abs = wr_cmd && i_hwdata[alarm_pkg::CMD_ABS_POS];
	wire cmd_home = wr_cmd && i_hwdata[alarm_pkg::CMD_HOME_DONE];
	wire gear_write = wr_hit(alarm_pkg::OFS_GEAR_NUM)
		|| wr_hit(alarm_pkg::OFS_GEAR_DEN);

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_take && i_hwrite;
			wr_addr_r <= i_haddr[7:0];
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= '0;
			ctrl_r <= alarm_pkg::CTRL_RESET;
			soft_fwd_r <= alarm_pkg::SOFT_FWD_RESET;
			soft_rev_r <= alarm_pkg::SOFT_REV_RESET;
			ovl_level_r <= alarm_pkg::OVL_LEVEL_RESET;
			gear_num_r <= alarm_pkg::GEAR_RESET;
			gear_den_r <= alarm_pkg::GEAR_RESET;
		end else begin
			if (wr_hit(alarm_pkg::OFS_MASK))
				mask_r <= i_hwdata[alarm_pkg::ALM_W-1:0];
			if (wr_hit(alarm_pkg::OFS_CTRL))
				ctrl_r <= i_hwdata[alarm_pkg::CTRL_W-1:0];
			if (wr_hit(alarm_pkg::OFS_SOFT_FWD))
				soft_fwd_r <= i_hwdata;
			if (wr_hit(alarm_pkg::OFS_SOFT_REV))
				soft_rev_r <= i_hwdata;
			if (wr_hit(alarm_pkg::OFS_OVL_LEVEL))
				ovl_level_r <= i_hwdata[15:0];
			if (wr_hit(alarm_pkg::OFS_GEAR_NUM))
				gear_num_r <= i_hwdata[15:0];
			if (wr_hit(alarm_pkg::OFS_GEAR_DEN))
				gear_den_r <= i_hwdata[15:0];
		end
	end

	wire abs_sys = ctrl_r[alarm_pkg::CTRL_ABS_SYSTEM];

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	alarm_timer_if ovl2_t ();
	alarm_timer_if abs_t ();

	alarm_timer #(.LIMIT(OVL2_LIMIT)) u_ovl2 (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.tmr(ovl2_t)
	);
	alarm_timer #(.LIMIT(ABS_LIMIT)) u_abs (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.tmr(abs_t)
	);

	assign ovl2_t.run = i_max_current; // R1
	// Waiting runs from data ready until the host raises its request.
	assign abs_t.run = i_abs_data_ready && !abs_req; // R8

	// ----------------------------------------------------------------
	// Overload pre-warning accumulator
	// ----------------------------------------------------------------
	// Time over the warning level is counted against the configured level;
	// a zero level or a cleared enable turns the pre-protection off.
	logic [15:0] load_cnt_r;
	logic [15:0] load_cnt_nxt;
	wire ovl_en = ctrl_r[alarm_pkg::CTRL_OVLWARN_EN]
		&& ovl_level_r != 16'h0000;
	assign load_cnt_nxt = (load_cnt_r == 16'hFFFF) ? load_cnt_r
		: load_cnt_r + 16'h0001;

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			load_cnt_r <= 16'h0000;
		end else if (!i_load_over_level || !ovl_en) begin
			load_cnt_r <= 16'h0000;
		end else begin
			load_cnt_r <= load_cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Positioning-command tracking
	// ----------------------------------------------------------------
	// Overflow memory and gear-change memory both survive until homing.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			home_done_r <= 1'b0;
			ovf_seen_r <= 1'b0;
			gear_dirty_r <= 1'b0;
		end else if (cmd_home) begin
			// An overflow in the homing cycle survives: set wins.
			home_done_r <= !i_feedback_overflow; // R13
			ovf_seen_r <= i_feedback_overflow;
			gear_dirty_r <= 1'b0;
		end else begin
			if (i_feedback_overflow)
				ovf_seen_r <= 1'b1;
			if (gear_write)
				gear_dirty_r <= 1'b1;
			if (gear_write || i_feedback_overflow)
				home_done_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Alarm conditions
	// ----------------------------------------------------------------
	logic [alarm_pkg::ALM_W-1:0] live;
	wire pos_inc = !abs_sys && cmd_abs && ovf_seen_r; // R9
	wire pos_ovf = abs_sys && i_feedback_overflow; // R10
	wire pos_gear = abs_sys && cmd_abs && gear_dirty_r; // R11
	wire pos_nohome = abs_sys && cmd_abs && !home_done_r; // R12

	assign live[alarm_pkg::ALM_OVL2] = ovl2_t.expired; // R1
	assign live[alarm_pkg::ALM_MISMATCH] = // R2
		(i_motor_capacity > i_drive_capacity)
		|| ({1'b0, i_motor_capacity} + {1'b0, alarm_pkg::CAP_SPAN}
		< {1'b0, i_drive_capacity}); // Nine bits, so a top code cannot wrap.
	assign live[alarm_pkg::ALM_ESTOP] = estop; // R3
	assign live[alarm_pkg::ALM_HWLIM] = fwd_lim || rev_lim; // R4
	assign live[alarm_pkg::ALM_SWFWD] = // R5
		$signed(i_feedback_count) > $signed(soft_fwd_r);
	assign live[alarm_pkg::ALM_SWREV] = // R6
		$signed(i_feedback_count) < $signed(soft_rev_r);
	assign live[alarm_pkg::ALM_OVLWARN] = ovl_en // R7
		&& load_cnt_r >= ovl_level_r;
	assign live[alarm_pkg::ALM_ABSTO] = abs_t.expired; // R8
	assign live[alarm_pkg::ALM_POSCMD] = pos_inc || pos_ovf || pos_gear
		|| pos_nohome;

	// ----------------------------------------------------------------
	// Sticky status and interrupt
	// ----------------------------------------------------------------
	// A new event in the clearing cycle survives: set wins over clear.
	// Homing clears only the command-error bit.
	logic [alarm_pkg::ALM_W-1:0] clr;
	assign clr = (wr_status ? i_hwdata[alarm_pkg::ALM_W-1:0] : '0)
		| (cmd_home ? alarm_pkg::ALM_W'(1) << alarm_pkg::ALM_POSCMD : '0); // R13

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~clr) | live; // R3
		end
	end

	assign o_irq = |(status_r & mask_r);

	// ----------------------------------------------------------------
	// Read data and outputs
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	logic [31:0] rdata_r;
	logic [alarm_pkg::ALM_W-1:0] live_r;

	always_comb begin
		case (rd_addr)
			alarm_pkg::OFS_STATUS: rd_mux = 32'(status_r);
			alarm_pkg::OFS_MASK: rd_mux = 32'(mask_r);
			alarm_pkg::OFS_CTRL: rd_mux = 32'(ctrl_r);
			alarm_pkg::OFS_SOFT_FWD: rd_mux = soft_fwd_r;
			alarm_pkg::OFS_SOFT_REV: rd_mux = soft_rev_r;
			alarm_pkg::OFS_OVL_LEVEL: rd_mux = 32'(ovl_level_r);
			alarm_pkg::OFS_GEAR_NUM: rd_mux = 32'(gear_num_r);
			alarm_pkg::OFS_GEAR_DEN: rd_mux = 32'(gear_den_r);
			alarm_pkg::OFS_LIVE: rd_mux = {22'h0, home_done_r, live_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is registered at the address phase, so no wait states.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
			live_r <= '0;
		end else begin
			live_r <= live;
			if (addr_take && !i_hwrite)
				rdata_r <= rd_mux;
		end
	end

	assign o_hrdata = rdata_r;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_home_done = home_done_r; // R13
	assign o_alarm_live = live_r;

endmodule

`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host controller answering the absolute-data handshake
// ----------------------------------------------------------------
module host_model (
	// Clock.
	input wire logic i_mclk,
	// Handshake.
	input wire logic i_abs_data_ready,
	input wire logic [7:0] i_delay,
	output logic o_abs_data_request
);
	int unsigned wait_n;

	// A delay of zero models a host that never answers.
	always @(posedge i_mclk) begin
		if (i_abs_data_ready !== 1'b1) begin
			wait_n <= 0;
			o_abs_data_request <= 1'b0;
		end else begin
			wait_n <= wait_n + 1;
			if (i_delay != 8'h00 && wait_n + 1 >= i_delay) begin
				o_abs_data_request <= 1'b1;
			end
		end
	end

	initial o_abs_data_request = 1'b0;
endmodule

`default_nettype wire

// ### verif/servo_alarm_monitor_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level alarm checker
// ----------------------------------------------------------------
module servo_alarm_monitor_chk #(
	parameter int unsigned OVL2_LIMIT = 20,
	parameter int unsigned ABS_LIMIT = 40
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Watched inputs.
	input wire logic i_emergency_stop_input,
	input wire logic i_forward_limit_input,
	input wire logic i_reverse_limit_input,
	input wire logic i_abs_data_request,
	input wire logic i_max_current,
	input wire logic i_abs_data_ready,
	input wire logic [7:0] i_drive_capacity,
	input wire logic [7:0] i_motor_capacity,
	// Watched outputs.
	input wire logic [alarm_pkg::ALM_W-1:0] o_alarm_live
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	int unsigned run_n;
	int unsigned wait_n;
	wire mis;
	wire lim;

	// Capacity pairing and either limit switch, as plain wires.
	assign mis = (i_motor_capacity > i_drive_capacity) ||
		({1'b0, i_motor_capacity} + 9'h001 < {1'b0, i_drive_capacity});
	assign lim = i_forward_limit_input || i_reverse_limit_input;

	// Unbroken run lengths; long windows are too big for a repetition.
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_n <= 0;
			wait_n <= 0;
		end else begin
			run_n <= i_max_current ? run_n + 1 : 0;
			wait_n <= (i_abs_data_ready && !i_abs_data_request) ?
				wait_n + 1 : 0;
		end
	end

	// A pin held long enough to cross the synchroniser.
	sequence s_held(sig);
		sig [*8];
	endsequence

	sequence s_steady(sig);
		sig [*5];
	endsequence

	chk_estop_raise: assert property (s_held(i_emergency_stop_input) |-> o_alarm_live[2])
		else $error("estop alarm missing");
	chk_estop_release: assert property (s_held(!i_emergency_stop_input) |-> !o_alarm_live[2])
		else $error("estop alarm stuck");
	chk_limit_raise: assert property (s_held(lim) |-> o_alarm_live[3])
		else $error("limit alarm missing");
	chk_limit_release: assert property (s_held(!lim) |-> !o_alarm_live[3])
		else $error("limit alarm stuck");
	chk_cap_bad: assert property (s_steady(mis) |-> o_alarm_live[1])
		else $error("mismatch alarm missing");
	chk_cap_good: assert property (s_steady(!mis) |-> !o_alarm_live[1])
		else $error("mismatch alarm false");
	chk_ovl2_late: assert property (run_n > OVL2_LIMIT + 4 |-> o_alarm_live[0])
		else $error("overload alarm late");
	chk_ovl2_early: assert property ($rose(o_alarm_live[0]) |-> run_n >= OVL2_LIMIT)
		else $error("overload alarm early");
	chk_abs_timeout: assert property (wait_n > ABS_LIMIT + 8 |-> o_alarm_live[7])
		else $error("abs timeout missing");
endmodule

bind servo_alarm_monitor servo_alarm_monitor_chk #(
	.OVL2_LIMIT(OVL2_LIMIT), .ABS_LIMIT(ABS_LIMIT)
) servo_alarm_monitor_chk_i (.i_mclk, .i_arst_n, .i_emergency_stop_input,
	.i_forward_limit_input, .i_reverse_limit_input, .i_abs_data_request,
	.i_max_current, .i_abs_data_ready, .i_drive_capacity,
	.i_motor_capacity, .o_alarm_live);

`default_nettype wire

// ### verif/servo_alarm_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none

module servo_alarm_monitor_test;
	localparam int unsigned OL = 20;
	localparam int unsigned AL = 40;
	logic i_mclk = 1'b0, i_arst_n = 1'b0;
	logic i_hsel = 1'b0, i_hwrite = 1'b0;
	logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
	logic [1:0] i_htrans = 2'h0;
	logic [2:0] i_hsize = 3'h2;
	logic i_emergency_stop_input = 1'b0, i_forward_limit_input = 1'b0;
	logic i_reverse_limit_input = 1'b0, i_abs_data_request;
	logic i_max_current = 1'b0, i_load_over_level = 1'b0;
	logic i_feedback_overflow = 1'b0, i_abs_data_ready = 1'b0;
	logic [31:0] i_feedback_count = 32'h0;
	logic [7:0] i_drive_capacity = 8'h05, i_motor_capacity = 8'h05;
	logic [7:0] delay = 8'h05;
	logic [31:0] o_hrdata;
	logic o_hreadyout, o_hresp, o_home_done, o_irq;
	logic [alarm_pkg::ALM_W-1:0] o_alarm_live;
	int n_fail = 0, n_compared = 0, cycles = 0;

	servo_alarm_monitor #(.OVL2_LIMIT(OL), .ABS_LIMIT(AL)) servo_alarm_monitor_i (
		.i_mclk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
		.i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp,
		.i_emergency_stop_input, .i_forward_limit_input, .i_reverse_limit_input,
		.i_abs_data_request, .i_max_current, .i_load_over_level,
		.i_feedback_count, .i_feedback_overflow, .i_drive_capacity,
		.i_motor_capacity, .i_abs_data_ready, .o_home_done, .o_alarm_live,
		.o_irq);

	host_model host_model_i (.i_mclk(i_mclk), .i_abs_data_ready(i_abs_data_ready),
		.i_delay(delay), .o_abs_data_request(i_abs_data_request));

	// ----------------------------------------------------------------
	// Clock, watchdog and helpers
	// ----------------------------------------------------------------
	// The clock toggles every 50 ns, for a period of 100 ns.
	always #50 i_mclk = ~i_mclk;

	// A hang is cut short well beyond the few hundred cycles needed.
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// Live vector, looked at once the edge has settled; the task then
	// returns on a rising edge so the next stimulus lands on the clock.
	task automatic live(input logic [8:0] exp);
		#1 chk({23'h0, o_alarm_live}, {23'h0, exp});
		@(posedge i_mclk);
	endtask

	// One AHB-Lite single transfer; waits for ready in both phases.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_mclk);
		i_hsel <= 1'b1;
		i_haddr <= {24'h000000, a};
		i_htrans <= alarm_pkg::HTRANS_NONSEQ;
		i_hwrite <= w;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		q = o_hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q & m, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] ofs[8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
			8'h1C, 8'h40};
		logic [31:0] rv[8] = '{32'h0, 32'h2, 32'h7FFF_FFFF, 32'h8000_0000,
			32'h2710, 32'h1, 32'h1, 32'h0};
		for (int i = 0; i < 8; i++) rd(ofs[i], 32'hFFFF_FFFF, rv[i]);
		wr(8'h40, 32'h5);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0);
		$display("test regs done");
	endtask

	// Estop, then each limit switch; sticky status drives the interrupt.
	task automatic t_pins();
		i_emergency_stop_input <= 1'b1;
		cyc(8);
		live(9'h004);
		cyc(30);
		live(9'h004);
		i_emergency_stop_input <= 1'b0;
		cyc(8);
		live(9'h000);
		wr(8'h04, 32'h4);
		#1 chk(o_irq, 1'b1);
		wr(8'h00, 32'h1FF);
		rd(8'h00, 32'h1FF, 32'h0);
		#1 chk(o_irq, 1'b0);
		@(posedge i_mclk);
		for (int i = 0; i < 2; i++) begin
			i_forward_limit_input <= (i == 0);
			i_reverse_limit_input <= (i == 1);
			cyc(8);
			live(9'h008);
		end
		i_reverse_limit_input <= 1'b0;
		cyc(8);
		live(9'h000);
		wr(8'h04, 32'h0);
		rd(8'h00, 32'h1FF, 32'h8);
		#1 chk(o_irq, 1'b0);
		wr(8'h00, 32'h1FF);
		$display("test pins done");
	endtask

	task automatic t_ovl2();
		i_max_current <= 1'b1;
		cyc(OL - 2);
		i_max_current <= 1'b0;
		cyc(1);
		i_max_current <= 1'b1;
		cyc(OL - 2);
		live(9'h000);
		cyc(6);
		live(9'h001);
		i_max_current <= 1'b0;
		cyc(4);
		$display("test ovl2 done");
	endtask

	task automatic t_cap();
		logic [7:0] mc[4] = '{8'h05, 8'h06, 8'h04, 8'h03};
		logic [8:0] ex[4] = '{9'h000, 9'h002, 9'h000, 9'h002};
		for (int i = 0; i < 4; i++) begin
			i_motor_capacity <= mc[i];
			cyc(5);
			live(ex[i]);
		end
		i_motor_capacity <= 8'h05;
		cyc(5);
		$display("test cap done");
	endtask

	task automatic t_soft();
		logic [31:0] fc[4] = '{32'd100, 32'd101, -32'sd100, -32'sd101};
		logic [8:0] ex[4] = '{9'h000, 9'h010, 9'h000, 9'h020};
		wr(8'h0C, 32'd100);
		wr(8'h10, -32'sd100);
		for (int i = 0; i < 4; i++) begin
			i_feedback_count <= fc[i];
			cyc(4);
			live(ex[i]);
		end
		i_feedback_count <= 32'h0;
		cyc(4);
		$display("test soft done");
	endtask

	// Pre-warning with a short level, then with the enable dropped.
	task automatic t_ovlw();
		wr(8'h14, 32'd10);
		i_load_over_level <= 1'b1;
		cyc(20);
		live(9'h040);
		wr(8'h08, 32'h0);
		cyc(20);
		live(9'h000);
		i_load_over_level <= 1'b0;
		wr(8'h08, 32'h2);
		$display("test ovlw done");
	endtask

	task automatic t_abs();
		i_abs_data_ready <= 1'b1;
		cyc(AL + 20);
		live(9'h000);
		i_abs_data_ready <= 1'b0;
		delay <= 8'h00;
		cyc(8);
		i_abs_data_ready <= 1'b1;
		cyc(AL + 20);
		live(9'h080);
		i_abs_data_ready <= 1'b0;
		delay <= 8'h05;
		cyc(8);
		wr(8'h00, 32'h1FF);
		$display("test abs done");
	endtask

	// Homing, overflow, gear change and commands in both systems.
	task automatic t_pos();
		wr(8'h08, 32'h3);
		wr(8'h24, 32'h1);
		rd(8'h00, 32'h100, 32'h100);
		wr(8'h24, 32'h2);
		rd(8'h00, 32'h100, 32'h0);
		#1 chk(o_home_done, 1'b1);
		@(posedge i_mclk);
		i_feedback_overflow <= 1'b1;
		cyc(1);
		i_feedback_overflow <= 1'b0;
		cyc(3);
		#1 chk(o_home_done, 1'b0);
		rd(8'h00, 32'h100, 32'h100);
		wr(8'h24, 32'h2);
		wr(8'h00, 32'h1FF);
		rd(8'h00, 32'h100, 32'h0);
		#1 chk(o_home_done, 1'b1);
		wr(8'h18, 32'h2);
		#1 chk(o_home_done, 1'b0);
		wr(8'h24, 32'h1);
		rd(8'h00, 32'h100, 32'h100);
		wr(8'h24, 32'h2);
		wr(8'h08, 32'h2);
		i_feedback_overflow <= 1'b1;
		cyc(1);
		i_feedback_overflow <= 1'b0;
		wr(8'h24, 32'h1);
		rd(8'h00, 32'h100, 32'h100);
		$display("test pos done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(8);
		i_arst_n <= 1'b1;
		cyc(4);
		t_regs();
		t_pins();
		t_ovl2();
		t_cap();
		t_soft();
		t_ovlw();
		t_abs();
		t_pos();
		complete_run();
	end
endmodule

`default_nettype wire
